// file: src/edp_core.sv
// cpu core datapath: opcode latch, address registers, scratchpad, accumulator and flags
`timescale 1ns/100ps
`default_nettype none
module edp_core
  import edp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  output logic [10:0]            rom_addr,
  input  wire logic [7:0]        rom_data,
  input  wire logic              irq_req,
  output logic                   irq_ack,
  output logic                   opcode_fetch,
  output logic [7:0]             opcode_latch,
  output logic [7:0]             accumulator,
  output logic [10:0]            instr_counter,
  output logic [10:0]            return_addr,
  output logic [10:0]            table_pointer,
  output logic [10:0]            aux_table_pointer,
  output logic [5:0]             scratch_index,
  output logic [4:0]             status_flags
);
  import edp_pkg::*;

  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  edp_state_t  state_reg, state_next;
  logic [7:0]  opcode_reg, opcode_next;
  logic [7:0]  acc_reg, acc_next;
  logic [10:0] pc_reg, pc_next;
  logic [10:0] ret_reg, ret_next;
  logic [10:0] dc_reg, dc_next;
  logic [10:0] dc1_reg, dc1_next;
  logic [5:0]  is_reg, is_next;
  logic [4:0]  flag_reg, flag_next;
  logic [7:0]  oper_reg, oper_next;
  logic [7:0]  scratch [0:SP_DEPTH-1];

  // ----------------------------------------------------------------
  // opcode decode
  // ----------------------------------------------------------------
  edp_group_t grp;
  edp_misc_t  misc;
  logic [3:0] low;
  logic       is_misc;
  logic       uses_reg;
  logic       alu_group;
  logic       alu_misc;
  logic       needs_oper;
  logic       two_byte;
  logic       privileged;
  logic       in_exec;
  logic       in_oper;

  assign grp        = edp_group_t'(opcode_reg[7:4]);
  assign low        = opcode_reg[3:0];
  assign misc       = edp_misc_t'(low);
  assign is_misc    = (grp == OP_MISC);
  assign in_exec    = (state_reg == S_EXEC);
  assign in_oper    = (state_reg == S_OPER);
  assign alu_group  = (grp == OP_ADD) || (grp == OP_ADC) || (grp == OP_AND) ||
                      (grp == OP_OR) || (grp == OP_XOR);
  assign uses_reg   = alu_group || (grp == OP_LDR) || (grp == OP_STR);
  assign alu_misc   = is_misc && ((misc == M_INC) || (misc == M_DEC) || (misc == M_COM) ||
                      (misc == M_SHR) || (misc == M_SHL) || (misc == M_DADJ));
  assign two_byte   = (grp == OP_LDP) || (is_misc && (misc == M_CALL));
  assign needs_oper = two_byte || (grp == OP_BRANCH) || (grp == OP_LDI) || (grp == OP_AI) ||
                      (is_misc && (misc == M_LDM));
  assign privileged = is_misc && ((misc == M_SETI) || (misc == M_CLRI) ||
                      (misc == M_CALL) || (misc == M_RET));

  // ----------------------------------------------------------------
  // scratchpad addressing
  // ----------------------------------------------------------------
  logic       sel_direct;
  logic [5:0] sp_addr;
  logic [7:0] sp_rdata;
  logic [2:0] is_low_inc;
  logic [2:0] is_low_dec;
  logic       sp_we;
  logic       save_we;

  assign sel_direct = (low < DIRECT_LIMIT);
  assign sp_addr    = sel_direct ? {2'b00, low} : is_reg;
  assign sp_rdata   = scratch[sp_addr];
  assign is_low_inc = is_reg[2:0] + 3'h1;
  assign is_low_dec = is_reg[2:0] - 3'h1;
  assign sp_we      = in_exec && (grp == OP_STR);
  assign save_we    = in_exec && is_misc && (misc == M_SAVEK);

  // ----------------------------------------------------------------
  // shared address adder
  // ----------------------------------------------------------------
  logic        rom_sel_dc;
  logic        addp_now;
  logic [10:0] add_a;
  logic [10:0] add_b;
  logic [10:0] add_sum;

  assign rom_sel_dc = in_oper && is_misc && (misc == M_LDM);
  assign addp_now   = in_exec && is_misc && (misc == M_ADDP);
  assign add_a      = (rom_sel_dc || addp_now) ? dc_reg : pc_reg;
  assign add_b      = (state_reg == S_BRANCH) ? {{3{oper_reg[7]}}, oper_reg} :
                      addp_now ? {{3{acc_reg[7]}}, acc_reg} : INC_ONE;
  assign add_sum    = add_a + add_b;
  assign rom_addr   = rom_sel_dc ? dc_reg : pc_reg;

  // ----------------------------------------------------------------
  // alu hookup
  // ----------------------------------------------------------------
  edp_aluop_t alu_op;
  logic [7:0] alu_b;
  logic [7:0] alu_res;
  logic       alu_c;
  logic       alu_v;
  logic       alu_s;
  logic       alu_z;

  // operation from group or misc sub-op
  always_comb
  begin
    alu_op = A_PASS;
    case (grp)
      OP_ADD, OP_AI: alu_op = A_ADD;
      OP_ADC:        alu_op = A_ADDC;
      OP_AND:        alu_op = A_AND;
      OP_OR:         alu_op = A_OR;
      OP_XOR:        alu_op = A_XOR;
      OP_MISC:
      begin
        case (misc)
          M_INC:   alu_op = A_INC;
          M_DEC:   alu_op = A_DEC;
          M_COM:   alu_op = A_COM;
          M_SHR:   alu_op = A_SHR;
          M_SHL:   alu_op = A_SHL;
          M_DADJ:  alu_op = A_DADJ;
          default: alu_op = A_PASS;
        endcase
      end
      default: alu_op = A_PASS;
    endcase
  end

  assign alu_b = (grp == OP_AI) ? rom_data : sp_rdata;

  edp_alu u_alu (
    .op        (alu_op),
    .a         (acc_reg),
    .b         (alu_b),
    .cin       (flag_reg[FL_CARRY]),
    .result    (alu_res),
    .carry_out (alu_c),
    .overflow  (alu_v),
    .sign      (alu_s),
    .zero      (alu_z)
  );

  // ----------------------------------------------------------------
  // completion and interrupt entry
  // ----------------------------------------------------------------
  logic branch_taken;
  logic instr_done;
  logic take_irq;

  assign branch_taken = (low == 4'h0) ||
                        ((low & {flag_reg[FL_OVF], flag_reg[FL_ZERO], flag_reg[FL_CARRY], flag_reg[FL_SIGN]})
                         != 4'h0);
  assign instr_done   = (in_exec && !needs_oper) ||
                        (in_oper && !two_byte && !((grp == OP_BRANCH) && branch_taken)) ||
                        (state_reg == S_OPER2) || (state_reg == S_BRANCH);
  assign take_irq     = instr_done && !privileged && flag_reg[FL_IRQEN] && irq_req;

  // ----------------------------------------------------------------
  // next-state and register updates
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next  = state_reg;
    opcode_next = opcode_reg;
    acc_next    = acc_reg;
    pc_next     = pc_reg;
    ret_next    = ret_reg;
    dc_next     = dc_reg;
    dc1_next    = dc1_reg;
    is_next     = is_reg;
    flag_next   = flag_reg;
    oper_next   = oper_reg;
    case (state_reg)
      S_FETCH:
      begin
        opcode_next = rom_data;
        pc_next     = add_sum;
        state_next  = S_EXEC;
      end
      S_EXEC:
      begin
        if (alu_group || alu_misc)
        begin
          acc_next = alu_res;
          flag_next[FL_CARRY] = alu_c;
          flag_next[FL_OVF]   = alu_v;
          flag_next[FL_SIGN]  = alu_s;
          flag_next[FL_ZERO]  = alu_z;
        end
        if (grp == OP_LDS)
          acc_next = {4'h0, low};
        if (grp == OP_LDR)
          acc_next = sp_rdata;
        if (uses_reg && (low == RSEL_IS_INC))
          is_next = {is_reg[5:3], is_low_inc};
        if (uses_reg && (low == RSEL_IS_DEC))
          is_next = {is_reg[5:3], is_low_dec};
        if (grp == OP_ISU)
          is_next = {low[2:0], is_reg[2:0]};
        if (grp == OP_ISL)
          is_next = {is_reg[5:3], low[2:0]};
        if (grp == OP_ISA)
          is_next = acc_reg[5:0];
        if (is_misc)
        begin
          case (misc)
            M_SWAP:
            begin
              dc_next  = dc1_reg;
              dc1_next = dc_reg;
            end
            M_SETI: flag_next[FL_IRQEN] = 1'b1;
            M_CLRI: flag_next[FL_IRQEN] = 1'b0;
            M_ADDP: dc_next = add_sum;
            M_RET:  pc_next = ret_reg;
            default: ;
          endcase
        end
        state_next = needs_oper ? S_OPER : (take_irq ? S_IRQ : S_FETCH);
      end
      S_OPER:
      begin
        if (rom_sel_dc)
          dc_next = add_sum;
        else
          pc_next = add_sum;
        oper_next = rom_data;
        if ((grp == OP_LDI) || rom_sel_dc)
          acc_next = rom_data;
        if (grp == OP_AI)
        begin
          acc_next = alu_res;
          flag_next[FL_CARRY] = alu_c;
          flag_next[FL_OVF]   = alu_v;
          flag_next[FL_SIGN]  = alu_s;
          flag_next[FL_ZERO]  = alu_z;
        end
        if (two_byte)
          state_next = S_OPER2;
        else if ((grp == OP_BRANCH) && branch_taken)
          state_next = S_BRANCH;
        else
          state_next = take_irq ? S_IRQ : S_FETCH;
      end
      S_OPER2:
      begin
        if (grp == OP_LDP)
        begin
          dc_next = {oper_reg[2:0], rom_data};
          pc_next = add_sum;
        end
        else
        begin
          ret_next = add_sum;
          pc_next  = {oper_reg[2:0], rom_data};
        end
        state_next = take_irq ? S_IRQ : S_FETCH;
      end
      S_BRANCH:
      begin
        pc_next    = add_sum;
        state_next = take_irq ? S_IRQ : S_FETCH;
      end
      S_IRQ:
      begin
        ret_next  = pc_reg;
        pc_next   = IRQ_VECTOR;
        flag_next[FL_IRQEN] = 1'b0;
        state_next = S_FETCH;
      end
      default: state_next = S_FETCH;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg  <= S_FETCH;
      opcode_reg <= OPCODE_RESET;
      acc_reg    <= ACC_RESET;
      pc_reg     <= RESET_ADDR;
      ret_reg    <= RESET_ADDR;
      dc_reg     <= RESET_ADDR;
      dc1_reg    <= RESET_ADDR;
      is_reg     <= IS_RESET;
      flag_reg   <= FLAG_RESET;
      oper_reg   <= 8'h00;
    end
    else
    begin
      state_reg  <= state_next;
      opcode_reg <= opcode_next;
      acc_reg    <= acc_next;
      pc_reg     <= pc_next;
      ret_reg    <= ret_next;
      dc_reg     <= dc_next;
      dc1_reg    <= dc1_next;
      is_reg     <= is_next;
      flag_reg   <= flag_next;
      oper_reg   <= oper_next;
    end
  end

  // ----------------------------------------------------------------
  // scratchpad write port
  // ----------------------------------------------------------------
  // return save split
  always_ff @(posedge clk)
  begin
    if (sp_we)
      scratch[sp_addr] <= acc_reg;
    if (save_we)
    begin
      scratch[SAVE_LO_IDX] <= ret_reg[7:0];
      scratch[SAVE_HI_IDX] <= {5'b00000, ret_reg[10:8]};
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // address registers visible
  assign opcode_fetch      = (state_reg == S_FETCH);
  assign irq_ack           = (state_reg == S_IRQ);
  assign opcode_latch      = opcode_reg;
  assign accumulator       = acc_reg;
  assign instr_counter     = pc_reg;
  assign return_addr       = ret_reg;
  assign table_pointer     = dc_reg;
  assign aux_table_pointer = dc1_reg;
  assign scratch_index     = is_reg;
  assign status_flags      = flag_reg;

endmodule
`default_nettype wire

// file: src/edp_pkg.sv
// constants and types shared by the eight-bit core datapath
package edp_pkg;

  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 11;
  localparam int DATA_W   = 8;
  localparam int SP_DEPTH = 64;
  localparam int IS_W     = 6;
  localparam int FLAG_W   = 5;

  // ----------------------------------------------------------------
  // addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [10:0] RESET_ADDR  = 11'h000;
  localparam logic [10:0] IRQ_VECTOR  = 11'h020; // service entry, arbitrary value
  localparam logic [10:0] INC_ONE     = 11'h001;
  localparam logic [7:0]  ACC_RESET   = 8'h00;
  localparam logic [5:0]  IS_RESET    = 6'h00;
  localparam logic [4:0]  FLAG_RESET  = 5'h00;
  localparam logic [7:0]  OPCODE_RESET = 8'h00;

  // scratchpad selection from the low opcode nibble, and the fixed return save slots
  localparam logic [3:0]  DIRECT_LIMIT = 4'hC;
  localparam logic [3:0]  RSEL_IS_INC  = 4'hD;
  localparam logic [3:0]  RSEL_IS_DEC  = 4'hE;
  localparam logic [5:0]  SAVE_LO_IDX  = 6'h0D;
  localparam logic [5:0]  SAVE_HI_IDX  = 6'h0C;

  // status flag positions
  localparam int FL_SIGN  = 0;
  localparam int FL_CARRY = 1;
  localparam int FL_ZERO  = 2;
  localparam int FL_OVF   = 3;
  localparam int FL_IRQEN = 4;

  // ----------------------------------------------------------------
  // instruction groups (upper nibble), misc sub-ops (lower nibble), alu operations and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_MISC = 4'h0, OP_BRANCH = 4'h1, OP_LDI = 4'h2, OP_LDS = 4'h3,
    OP_LDR  = 4'h4, OP_STR    = 4'h5, OP_ADD = 4'h6, OP_ADC = 4'h7,
    OP_AND  = 4'h8, OP_OR     = 4'h9, OP_XOR = 4'hA, OP_ISU = 4'hB,
    OP_ISL  = 4'hC, OP_ISA    = 4'hD, OP_AI  = 4'hE, OP_LDP = 4'hF
  } edp_group_t;

  typedef enum logic [3:0] {
    M_NOP  = 4'h0, M_SWAP = 4'h1, M_SAVEK = 4'h2, M_INC  = 4'h3,
    M_DEC  = 4'h4, M_COM  = 4'h5, M_SHR   = 4'h6, M_SHL  = 4'h7,
    M_DADJ = 4'h8, M_SETI = 4'h9, M_CLRI  = 4'hA, M_ADDP = 4'hB,
    M_LDM  = 4'hC, M_CALL = 4'hD, M_RET   = 4'hE, M_RSV  = 4'hF
  } edp_misc_t;

  typedef enum logic [3:0] {
    A_PASS = 4'h0, A_ADD = 4'h1, A_ADDC = 4'h2, A_DADJ = 4'h3,
    A_INC  = 4'h4, A_DEC = 4'h5, A_AND  = 4'h6, A_OR   = 4'h7,
    A_XOR  = 4'h8, A_COM = 4'h9, A_SHR  = 4'hA, A_SHL  = 4'hB
  } edp_aluop_t;

  typedef enum logic [2:0] {
    S_FETCH = 3'b000, S_EXEC = 3'b001, S_OPER = 3'b010,
    S_OPER2 = 3'b011, S_BRANCH = 3'b100, S_IRQ = 3'b101
  } edp_state_t;

endpackage

// file: src/edp_alu.sv
// eight-bit arithmetic and logic unit with result flags
`timescale 1ns/100ps
`default_nettype none
module edp_alu
  import edp_pkg::*;
(
  input  wire edp_pkg::edp_aluop_t op,
  input  wire logic [7:0]          a,
  input  wire logic [7:0]          b,
  input  wire logic                cin,
  output logic [7:0]               result,
  output logic                     carry_out,
  output logic                     overflow,
  output logic                     sign,
  output logic                     zero
);
  import edp_pkg::*;

  logic [7:0] addend;
  logic       add_cin;
  logic       arith;
  logic [8:0] sum9;
  logic [7:0] low7;
  logic [7:0] logic_res;

  // ----------------------------------------------------------------
  // operand shaping for the adder
  // ----------------------------------------------------------------
  // arithmetic operation select
  always_comb
  begin
    addend  = b;
    add_cin = 1'b0;
    arith   = 1'b1;
    case (op)
      A_ADD:  addend = b;
      A_ADDC: add_cin = cin;
      A_INC:  addend = 8'h01;
      A_DEC:  addend = 8'hFF;
      A_DADJ: addend = {((a[7:4] > 4'h9) || cin) ? 4'h6 : 4'h0, (a[3:0] > 4'h9) ? 4'h6 : 4'h0};
      default: arith = 1'b0;
    endcase
  end

  assign sum9 = {1'b0, a} + {1'b0, addend} + {8'h00, add_cin};
  assign low7 = {1'b0, a[6:0]} + {1'b0, addend[6:0]} + {7'h00, add_cin};

  always_comb
  begin
    case (op)
      A_AND:   logic_res = a & b;
      A_OR:    logic_res = a | b;
      A_XOR:   logic_res = a ^ b;
      A_COM:   logic_res = ~a;
      A_SHR:   logic_res = {1'b0, a[7:1]};
      A_SHL:   logic_res = {a[6:0], 1'b0};
      default: logic_res = b;
    endcase
  end

  // ----------------------------------------------------------------
  // result and flags
  // ----------------------------------------------------------------
  // flags beside result
  assign result    = arith ? sum9[7:0] : logic_res;
  assign carry_out = arith & (sum9[8] | ((op == A_DADJ) & cin));
  assign overflow  = arith & (sum9[8] ^ low7[7]);
  assign sign      = result[7];
  assign zero      = (result == 8'h00);

endmodule
`default_nettype wire

// file: verification/edp_core_properties.sv
// concurrent checks on the core datapath ports
`timescale 1ns/100ps
`default_nettype none
module edp_core_properties
  import edp_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [10:0] rom_addr,
  input wire logic [7:0]  rom_data,
  input wire logic        irq_req,
  input wire logic        irq_ack,
  input wire logic        opcode_fetch,
  input wire logic [7:0]  opcode_latch,
  input wire logic [7:0]  accumulator,
  input wire logic [10:0] instr_counter,
  input wire logic [10:0] return_addr,
  input wire logic [10:0] table_pointer,
  input wire logic [10:0] aux_table_pointer,
  input wire logic [5:0]  scratch_index,
  input wire logic [4:0]  status_flags
);
  // ----------------------------------------------------------------
  // fetch, address, interrupt, index and flag relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  reset_fetch_a: assert property (
    $fell(srst) |-> opcode_fetch && rom_addr == RESET_ADDR && instr_counter == RESET_ADDR)
    else $error("fetch after reset not at zero");
  opcode_capture_a: assert property (
    opcode_fetch && !srst |=> opcode_latch == $past(rom_data)) else $error("opcode byte not latched");
  fetch_addr_a: assert property (
    opcode_fetch |-> rom_addr == instr_counter) else $error("fetch address not the counter");
  fetch_step_a: assert property (
    opcode_fetch && !srst |=> instr_counter == $past(instr_counter) + INC_ONE) else $error("counter did not step");
  irq_gate_a: assert property (
    irq_ack |-> $past(status_flags[FL_IRQEN]) && $past(irq_req)) else $error("ack without accept bit");
  irq_entry_a: assert property (
    irq_ack |=> instr_counter == IRQ_VECTOR && return_addr == $past(instr_counter)
      && !status_flags[FL_IRQEN] && opcode_fetch) else $error("bad interrupt entry");
  irq_pulse_a: assert property (
    irq_ack |=> !irq_ack) else $error("ack longer than one cycle");
  index_half_a: assert property (
    $changed(scratch_index) |-> scratch_index[5:3] == $past(scratch_index[5:3])
      || scratch_index[2:0] == $past(scratch_index[2:0]) || opcode_latch[7:4] == 4'hD)
    else $error("index changed both halves");
  flag_result_a: assert property (
    $changed(status_flags[3:0]) |-> status_flags[FL_SIGN] == accumulator[7]
      && status_flags[FL_ZERO] == (accumulator == 8'h00)) else $error("sign or zero flag wrong");
  irq_seen_c: cover property (irq_ack);
endmodule

bind edp_core edp_core_properties u_props (
  .clk(clk), .srst(srst), .rom_addr(rom_addr), .rom_data(rom_data), .irq_req(irq_req),
  .irq_ack(irq_ack), .opcode_fetch(opcode_fetch), .opcode_latch(opcode_latch),
  .accumulator(accumulator), .instr_counter(instr_counter), .return_addr(return_addr),
  .table_pointer(table_pointer), .aux_table_pointer(aux_table_pointer),
  .scratch_index(scratch_index), .status_flags(status_flags)
);
`default_nettype wire

// file: verification/edp_rom_model.sv
// program rom and interrupt requester facing the core
`timescale 1ns/100ps
`default_nettype none
module edp_rom_model (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [10:0] rom_addr,
  output logic [7:0]       rom_data,
  input  wire logic        irq_raise,
  output logic             irq_req = 1'b0,
  input  wire logic        irq_ack
);
  logic [7:0] mem [0:2047];

  // combinational read, byte zero first
  assign rom_data = mem[rom_addr];

  // request level held until the core acknowledges it
  always @(posedge clk)
    if (srst)
      irq_req <= 1'b0;
    else if (irq_ack)
      irq_req <= 1'b0;
    else if (irq_raise)
      irq_req <= 1'b1;
endmodule
`default_nettype wire

// file: verification/edp_core_tb.sv
// self-checking bench running two short programs through the core
`timescale 1ns/100ps
`default_nettype none
module edp_core_tb;
  import edp_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        irq_raise = 1'b0;
  logic        mon_on = 1'b0;
  logic [10:0] rom_addr, instr_counter, return_addr, table_pointer, aux_table_pointer;
  logic [7:0]  rom_data, opcode_latch, accumulator, rnd;
  logic [5:0]  scratch_index;
  logic [4:0]  status_flags;
  logic        irq_req, irq_ack, opcode_fetch;
  logic [18:0] exp_q[$];
  int          fail_count = 0;
  int          n_checks = 0;
  int          seed = 77696;
  int          k;
  // program: alu work, scratchpad, accept bit, handler at the vector
  logic [7:0]  prog [0:41] = '{8'h35, 8'h20, 8'h7F, 8'hE0, 8'h01, 8'h03, 8'h05, 8'h53, 8'h34, 8'h43,
    8'h63, 8'h07, 8'h06, 8'hA3, 8'h04, 8'h04, 8'h73, 8'hD0, 8'h5D, 8'h5E, 8'h34, 8'h4E, 8'h09,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'hB1, 8'hC5, 8'h4F,
    8'hC4, 8'h4F, 8'h20, 8'h00, 8'h10, 8'hFE};
  // accumulator, index, flags seen at each fetch
  logic [23:0] exp_tab [0:28] = '{24'h000000, 24'h050000, 24'h7F0000, 24'h800009, 24'h810001,
    24'h7E0000, 24'h7E0000, 24'h040000, 24'h7E0000, 24'hFC0009, 24'hF80001, 24'h7C0000,
    24'h020000, 24'h010002, 24'h000006, 24'h7F0000, 24'h7F3F00, 24'h7F3800, 24'h7F3F00,
    24'h043F00, 24'h7F3E00, 24'h7F3E10, 24'h7F3E00, 24'h7F3E00, 24'h7F0E00, 24'h7F0D00,
    24'h180D00, 24'h180C00, 24'h000C00};
  // second program: pointer load and swap, table reads, pointer add, decimal adjust, call, branches
  logic [7:0]  prog2 [0:24] = '{8'hF0, 8'h00, 8'h30, 8'h01, 8'h01, 8'h0C, 8'h0C, 8'h0B, 8'h08, 8'h0D,
    8'h00, 8'h18, 8'h12, 8'h05, 8'h01, 8'h04, 8'h12, 8'h02, 8'h35, 8'h00, 8'h09, 8'h0A, 8'h10, 8'hFE, 8'h0E};
  // accumulator, index, flags seen at each fetch of the second program
  logic [23:0] exp2 [0:15] = '{24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h270000, 24'h3C0000,
    24'h3C0000, 24'h420000, 24'h420000, 24'h420000, 24'h420000, 24'h420000, 24'h410002, 24'h410002,
    24'h410012, 24'h410002};

  always #20 clk = ~clk;

  edp_core DUT (.clk(clk), .srst(srst), .rom_addr(rom_addr), .rom_data(rom_data), .irq_req(irq_req),
    .irq_ack(irq_ack), .opcode_fetch(opcode_fetch), .opcode_latch(opcode_latch),
    .accumulator(accumulator), .instr_counter(instr_counter), .return_addr(return_addr),
    .table_pointer(table_pointer), .aux_table_pointer(aux_table_pointer),
    .scratch_index(scratch_index), .status_flags(status_flags));
  edp_rom_model rom (.clk(clk), .srst(srst), .rom_addr(rom_addr), .rom_data(rom_data),
    .irq_raise(irq_raise), .irq_req(irq_req), .irq_ack(irq_ack));

  task automatic check(input logic [18:0] got, input logic [18:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // compare settled state in every fetch cycle against the oldest note
  always @(negedge clk)
    if (mon_on && opcode_fetch === 1'b1 && exp_q.size() > 0)
      check({accumulator, scratch_index, status_flags}, exp_q.pop_front());

  // load rom, note expectations, release reset, raise request early
  initial
  begin
    rnd = 8'($random(seed));
    for (int i = 0; i < 2048; i++)
      rom.mem[i] = (i < 42) ? prog[i] : 8'h00;
    rom.mem[39] = rnd;
    for (int i = 0; i < 29; i++)
      exp_q.push_back({exp_tab[i][23:16], exp_tab[i][13:8], exp_tab[i][4:0]});
    exp_q.push_back({rnd, 6'h0C, 5'h00});
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    mon_on <= 1'b1;
    irq_raise <= 1'b1;
    @(posedge clk);
    irq_raise <= 1'b0;
    for (k = 0; k < 400 && exp_q.size() > 0; k++)
      @(posedge clk);
    if (exp_q.size() > 0)
      fail_count++;
    $display("program test done");
    @(negedge clk);
    check({8'h00, return_addr}, {8'h00, 11'h018});
    check({18'h00000, irq_req}, 19'h00000);
    $display("return test done");
    // mid-run reset, then reload rom and notes for the second program
    @(posedge clk);
    srst <= 1'b1;
    mon_on <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 2048; i++)
      rom.mem[i] = (i < 25) ? prog2[i] : 8'h00;
    rom.mem[48] = 8'h27;
    rom.mem[49] = 8'h3C;
    for (int i = 0; i < 16; i++)
      exp_q.push_back({exp2[i][23:16], exp2[i][13:8], exp2[i][4:0]});
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    mon_on <= 1'b1;
    for (k = 0; k < 400 && exp_q.size() > 0; k++)
      @(posedge clk);
    if (exp_q.size() > 0)
      fail_count++;
    @(negedge clk);
    check({8'h00, table_pointer}, {8'h00, 11'h000});
    check({8'h00, aux_table_pointer}, {8'h00, 11'h06E});
    check({8'h00, return_addr}, {8'h00, 11'h00C});
    $display("pointer test done");
    give_verdict();
  end
endmodule
`default_nettype wire
